// [logic/hpc_port_cfg.sv]
`timescale 1ns/1ps
`default_nettype none
module hpc_port_cfg
  import hpc_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              ce_i,
  input  wire hpc_bus_t          bus_i,
  output logic      [15:0]       rdata_o,
  output logic                   portb_wr_ready_o,
  input  wire logic              group1_request_line_i,
  input  wire logic [7:0]        portb_in_i,
  output logic      [7:0]        portb_out_o,
  output logic                   portb_oe_o,
  input  wire logic [7:0]        portd_in_i,
  output logic      [7:0]        portd_out_o,
  output logic                   portd_oe_o,
  output logic                   group2_acknowledge_line_o,
  output logic                   extra_output_two_o,
  output logic                   portb_handshake_active_o,
  output logic                   portd_handshake_active_o
);

  // ========================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire wr_g2   = bus_i.wr && hit(bus_i.addr, OFS_G2CFG);  // Group two write
  wire wr_xfer = bus_i.wr && hit(bus_i.addr, OFS_XFER);   // Transfer config write
  wire wr_pb   = bus_i.wr && hit(bus_i.addr, OFS_PORTB);  // Port B data write
  wire wr_pd   = bus_i.wr && hit(bus_i.addr, OFS_PORTD);  // Port D data write
  wire wr_g1   = bus_i.wr && hit(bus_i.addr, OFS_G1CFG);  // Group one write

  // ========================================================
  // Configuration state
  logic [15:0] g2cfg;        // group2_handshake_config
  logic [15:0] xfer;         // port_transfer_config
  logic [15:0] g1cfg;        // Group one control
  logic [7:0]  pd_out;       // Port D output latch
  logic [7:0]  stage1;       // Port B first buffer
  logic        stage1_full;  // First buffer awaits a request
  logic [7:0]  stage2;       // Port B second buffer
  logic [7:0]  pb_in_latch;  // Port B input buffer
  logic        armed1;       // Port B output handshake armed
  logic        armed2;       // Port D output handshake armed

  // Named configuration bits
  wire dbl_b = xfer[XF_DBLB_BIT];    // portb_double_buffer
  wire dir_b = xfer[XF_DIRB_BIT];    // portb_direction
  wire dir_d = xfer[XF_DIRD_BIT];    // portd_direction
  wire ack_man = g2cfg[G2_ACKMAN_BIT]; // group2_ack_manual
  wire ack_inv = g2cfg[G2_ACKINV_BIT]; // group2_ack_invert
  wire en_d = g2cfg[G2_DEN_BIT];     // portd_handshake_enable
  wire en_b = g1cfg[G1_BEN_BIT];     // portb_handshake_enable

  // ========================================================
  // Edge watcher for request line and control bits
  logic [EV_W-1:0] ev_lvl;   // Levels watched
  logic [EV_W-1:0] ev_rise;  // Rising edges
  logic [EV_W-1:0] ev_fall;  // Falling edges

  assign ev_lvl = {en_d, en_b, dir_d, dir_b, g2cfg[G2_LRST_BIT],
                   g1cfg[G1_LRST_BIT], group1_request_line_i};

  hpc_edge_det #(.W(EV_W)) u_edges (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .ce_i       (ce_i),
    .sig_i      (ev_lvl),
    .rise_o     (ev_rise),
    .fall_o     (ev_fall)
  );

  wire group1_request_line_go = ev_rise[EV_GROUP1_REQUEST_LINE];   // Active edge of group-one request
  wire lrst1   = ev_fall[EV_LRST1];  // Group one reset released
  wire lrst2   = ev_fall[EV_LRST2];  // Group two reset released

  // ========================================================
  // Port B write buffer in front of the first buffer
  logic       fifo_valid;  // Word waiting for the first buffer
  logic       fifo_ready;  // Room for a host write
  logic [7:0] fifo_data;   // Oldest waiting word
  wire        drain_ok;    // First buffer can take a word
  wire        drain;       // Word moves into the first buffer
  wire        xfer_go;     // First buffer moves to the second

  // Double-buffered output holds the first buffer until a request
  assign drain_ok = !dbl_b || !stage1_full || xfer_go;
  assign drain    = ce_i && fifo_valid && drain_ok;
  assign xfer_go  = dbl_b && dir_b && armed1 && stage1_full && group1_request_line_go;

  hpc_pair_buf #(.WIDTH(PORT_W)) u_pb_buf (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .ce_i        (ce_i),
    .flush_i     (lrst1),
    .in_valid_i  (wr_pb),
    .in_ready_o  (fifo_ready),
    .in_data_i   (bus_i.wdata[7:0]),
    .out_valid_o (fifo_valid),
    .out_ready_i (drain_ok),
    .out_data_o  (fifo_data)
  );

  assign portb_wr_ready_o = fifo_ready;

  // ========================================================
  // Configuration registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      g2cfg <= CFG_RST;
      xfer  <= CFG_RST;
      g1cfg <= CFG_RST;
    end else if (ce_i) begin
      if (wr_xfer) xfer <= bus_i.wdata;
      if (wr_g1) g1cfg <= bus_i.wdata;
      if (wr_g2) begin
        g2cfg <= bus_i.wdata;
      end else if (lrst2) begin
        // Handshake setup of group two must be written again
        g2cfg[G2_ACKMAN_BIT] <= 1'b0;
        g2cfg[G2_ACKINV_BIT] <= 1'b0;
        g2cfg[G2_DEN_BIT]    <= 1'b0;
      end
    end
  end

  // ========================================================
  // Handshake arming; a local reset disarms until re-armed
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed1 <= 1'b0;
      armed2 <= 1'b0;
    end else if (ce_i) begin
      if (lrst1) begin
        armed1 <= 1'b0;
      end else if (ev_rise[EV_DIRB] || ev_rise[EV_BEN]) begin
        armed1 <= 1'b1;
      end
      if (lrst2) begin
        armed2 <= 1'b0;
      end else if (ev_rise[EV_DIRD] || ev_rise[EV_DEN]) begin
        armed2 <= 1'b1;
      end
    end
  end

  // ========================================================
  // Port B buffers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage1      <= PORT_RST;
      stage1_full <= 1'b0;
      stage2      <= PORT_RST;
      pb_in_latch <= PORT_RST;
    end else if (ce_i) begin
      if (lrst1) begin
        stage1_full <= 1'b0;
      end else if (drain) begin
        stage1      <= fifo_data;
        stage1_full <= dbl_b;
      end else if (xfer_go || !dbl_b) begin
        stage1_full <= 1'b0;
      end
      if (xfer_go) stage2 <= stage1;
      // Input buffer takes the pins on the request edge
      if (dbl_b && !dir_b && group1_request_line_go) pb_in_latch <= portb_in_i;
    end
  end

  // Port D output latch
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pd_out <= PORT_RST;
    end else if (ce_i && wr_pd) begin
      pd_out <= bus_i.wdata[7:0];
    end
  end

  // ========================================================
  // Pin drive
  assign portb_oe_o  = dir_b;
  assign portb_out_o = dbl_b ? stage2 : stage1;
  assign portd_oe_o  = dir_d;
  assign portd_out_o = pd_out;
  assign extra_output_two_o = g2cfg[G2_EXTRA_OUTPUT_TWO_BIT];
  // Manual bit asserts; invert bit picks the asserted level
  assign group2_acknowledge_line_o = ack_man ^ ack_inv;
  assign portd_handshake_active_o = en_d && (armed2 || !dir_d);
  assign portb_handshake_active_o = en_b && (armed1 || !dir_b);

  // ========================================================
  // Read path; write-only and unmapped addresses read zero
  hpc_status_t status;      // Status word
  logic [15:0] pb_rd;       // Port B read value
  logic [15:0] pd_rd;       // Port D read value
  logic [15:0] rd_word;     // Selected read value

  assign status = '{zero: 10'h000, armed2: armed2, armed1: armed1,
                    stage1_full: stage1_full, fifo_valid: fifo_valid,
                    fifo_ready: fifo_ready, group1_request_line_level: group1_request_line_i};
  // Input reads buffer or live pins; output reads what is driven
  assign pb_rd = {8'h00, dir_b ? portb_out_o : (dbl_b ? pb_in_latch : portb_in_i)};
  assign pd_rd = {8'h00, dir_d ? pd_out : portd_in_i};
  assign rd_word = hit(bus_i.addr, OFS_PORTB)  ? pb_rd :
                   hit(bus_i.addr, OFS_PORTD)  ? pd_rd :
                   hit(bus_i.addr, OFS_STATUS) ? status : 16'h0000;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= bus_i.rd ? rd_word : 16'h0000;
    end
  end

  // ========================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  wire wr_g2_en = ce_i && wr_g2;  // Group two write taken

  // Pin follows manual and invert bits after a write
  ack_level_a: assert property (
    ce_i && wr_g2 |=> group2_acknowledge_line_o ==
      ($past(bus_i.wdata[G2_ACKMAN_BIT]) ^ $past(bus_i.wdata[G2_ACKINV_BIT])))
    else $error("Acknowledge pin does not follow written bits");

  // Pin holds while no group two write is near
  ack_hold_a: assert property (
    !$past(wr_g2_en) && !$past(wr_g2_en, 2) |-> $stable(group2_acknowledge_line_o))
    else $error("Acknowledge pin moved without a write");

  // Extra output follows bit zero
  extra_output_two_follow_a: assert property (
    ce_i && wr_g2 |=> extra_output_two_o == $past(bus_i.wdata[G2_EXTRA_OUTPUT_TWO_BIT]))
    else $error("Extra output does not follow bit zero");

  // Transfer config taken whole at its offset
  xfer_decode_a: assert property (
    ce_i && wr_xfer |=> xfer == $past(bus_i.wdata))
    else $error("Transfer config not taken at its offset");

  // Request moves the first buffer out; a waiting word refills it
  dbl_move_a: assert property (
    ce_i && xfer_go |=> portb_out_o == $past(stage1) &&
      stage1_full == ($past(drain) && !$past(lrst1)))
    else $error("Second buffer not loaded on request");

  // Single buffer reaches the pins on the drain edge
  single_out_a: assert property (
    ce_i && drain && !dbl_b && !lrst1 |=> portb_out_o == $past(fifo_data))
    else $error("Single buffer not driven at once");

  // Double-buffered pins change only on a request
  dbl_hold_a: assert property (
    ce_i && dbl_b && !xfer_go && !wr_xfer |=> $stable(portb_out_o))
    else $error("Double-buffered pins moved without request");

  // Input buffer holds between request edges
  in_hold_a: assert property (
    ce_i && !(dbl_b && !dir_b && group1_request_line_go) |=> $stable(pb_in_latch))
    else $error("Input buffer changed without request");

  // Read right after the request returns the latched pins
  in_latch_a: assert property (
    ce_i && dbl_b && !dir_b && group1_request_line_go ##1 ce_i && bus_i.rd && hit(bus_i.addr, OFS_PORTB) && !group1_request_line_go
      |=> rdata_o[7:0] == $past(portb_in_i, 2))
    else $error("Input buffer not returned on read");

  // Transparent read shows the pins of the strobe cycle
  live_read_a: assert property (
    ce_i && bus_i.rd && hit(bus_i.addr, OFS_PORTB) && !dbl_b && !dir_b
      |=> rdata_o[7:0] == $past(portb_in_i))
    else $error("Transparent read does not show pins");

  // Port D drive enable follows bit fourteen
  dir_d_a: assert property (
    ce_i && wr_xfer |=> portd_oe_o == $past(bus_i.wdata[XF_DIRD_BIT]))
    else $error("Port D direction wrong");

  // Port D drives the last written word
  pd_drive_a: assert property (
    ce_i && wr_pd |=> portd_out_o == $past(bus_i.wdata[7:0]))
    else $error("Port D drive value not written");

  // Port B drive enable follows bit thirteen
  dir_b_a: assert property (
    ce_i && wr_xfer |=> portb_oe_o == $past(bus_i.wdata[XF_DIRB_BIT]))
    else $error("Port B direction wrong");

  // Read data stand for one cycle only
  rd_zero_a: assert property (
    ce_i && !bus_i.rd |=> rdata_o == 16'h0000)
    else $error("Read data held past one cycle");

  // The write-only transfer config reads as zero
  wo_read_a: assert property (
    ce_i && bus_i.rd && hit(bus_i.addr, OFS_XFER) |=> rdata_o == 16'h0000)
    else $error("Write-only register returned data");

  // Group one reset empties and disarms port B
  lrst1_clear_a: assert property (
    ce_i && lrst1 |=> !armed1 && !stage1_full && fifo_ready)
    else $error("Group one reset left port B state");

  // Rising direction or enable arms port B
  rearm_b_a: assert property (
    ce_i && !lrst1 && (ev_rise[EV_DIRB] || ev_rise[EV_BEN]) |=> armed1)
    else $error("Port B handshake not re-armed");

  // Rising direction or enable arms port D
  rearm_d_a: assert property (
    ce_i && !lrst2 && (ev_rise[EV_DIRD] || ev_rise[EV_DEN]) |=> armed2)
    else $error("Port D handshake not re-armed");

  // Group two reset clears its handshake setup
  lrst_clear_a: assert property (
    ce_i && lrst2 && !wr_g2 |=> !ack_inv && !ack_man && !armed2 && !portd_handshake_active_o)
    else $error("Group two reset left handshake setup");

endmodule
`default_nettype wire

// [logic/hpc_pkg.sv]
`default_nettype none
// ==========================================================
// Shared constants and types of the handshake port block
package hpc_pkg;

  // ========================================================
  // Widths
  localparam int unsigned ADDR_W  = 8;       // Register address width
  localparam int unsigned DATA_W  = 16;      // Register data width
  localparam int unsigned PORT_W  = 8;       // Width of ports B and D
  localparam int unsigned EV_W    = 7;       // Number of watched edges

  // ========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_G2CFG  = 8'h00; // group2_handshake_config
  localparam logic [7:0] OFS_XFER   = 8'h04; // port_transfer_config
  localparam logic [7:0] OFS_PORTB  = 8'h08; // Port B data
  localparam logic [7:0] OFS_PORTD  = 8'h0C; // Port D data
  localparam logic [7:0] OFS_G1CFG  = 8'h10; // Group one control
  localparam logic [7:0] OFS_STATUS = 8'h14; // Block status

  // ========================================================
  // Field positions
  localparam int unsigned G2_EXTRA_OUTPUT_TWO_BIT   = 0;  // extra_output_two
  localparam int unsigned G2_ACKMAN_BIT = 1;  // group2_ack_manual
  localparam int unsigned G2_ACKINV_BIT = 2;  // group2_ack_invert
  localparam int unsigned G2_LRST_BIT   = 8;  // group2_local_reset
  localparam int unsigned G2_DEN_BIT    = 10; // portd_handshake_enable
  localparam int unsigned XF_DIRB_BIT   = 13; // portb_direction
  localparam int unsigned XF_DIRD_BIT   = 14; // portd_direction
  localparam int unsigned XF_DBLB_BIT   = 15; // portb_double_buffer
  localparam int unsigned G1_BEN_BIT    = 0;  // portb_handshake_enable
  localparam int unsigned G1_LRST_BIT   = 8;  // group1_local_reset

  // Positions in the edge watcher vector
  localparam int unsigned EV_GROUP1_REQUEST_LINE  = 0;      // group1_request_line
  localparam int unsigned EV_LRST1 = 1;      // group1_local_reset
  localparam int unsigned EV_LRST2 = 2;      // group2_local_reset
  localparam int unsigned EV_DIRB  = 3;      // portb_direction
  localparam int unsigned EV_DIRD  = 4;      // portd_direction
  localparam int unsigned EV_BEN   = 5;      // portb_handshake_enable
  localparam int unsigned EV_DEN   = 6;      // portd_handshake_enable

  // ========================================================
  // Values after reset
  localparam logic [15:0] CFG_RST  = 16'h0000; // All configuration clear
  localparam logic [7:0]  PORT_RST = 8'h00;    // Port data clear

  // ========================================================
  // Types
  typedef struct packed {
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
    logic [7:0]  addr;  // Byte address
    logic [15:0] wdata; // Write data
  } hpc_bus_t;

  typedef struct packed {
    logic [9:0] zero;        // Reads as zero
    logic       armed2;      // Port D handshake armed
    logic       armed1;      // Port B handshake armed
    logic       stage1_full; // First buffer holds a word
    logic       fifo_valid;  // Write buffer holds a word
    logic       fifo_ready;  // Write buffer has room
    logic       group1_request_line_level;  // Current group-one request level
  } hpc_status_t;

endpackage
`default_nettype wire

// [logic/hpc_edge_det.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Rise and fall detector for a vector of levels
module hpc_edge_det
  import hpc_pkg::*;
#(
  parameter int unsigned W = EV_W
) (
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] sig_i,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  logic [W-1:0] prev;  // Level seen at the last enabled edge

  // Edges are level now against level before
  assign rise_o = sig_i & ~prev;
  assign fall_o = ~sig_i & prev;

  // ========================================================
  // History register, frozen while ce is low
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev <= '0;
    end else if (ce_i) begin
      prev <= sig_i;
    end
  end

endmodule
`default_nettype wire

// [logic/hpc_pair_buf.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-entry buffer with valid and ready on both sides
module hpc_pair_buf
  import hpc_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] mem [2];   // Two storage words
  logic             wp;        // Write slot
  logic             rp;        // Read slot
  logic [1:0]       cnt;       // Words held
  wire              push;      // Word taken in
  wire              pop;       // Word handed out

  // Honest full and empty
  assign in_ready_o  = (cnt != 2'h2);
  assign out_valid_o = (cnt != 2'h0);
  assign out_data_o  = mem[rp];
  assign push        = ce_i && in_valid_i && in_ready_o;
  assign pop         = ce_i && out_valid_o && out_ready_i;

  // ========================================================
  // Pointers and count; flush empties the buffer
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else if (ce_i && flush_i) begin
      wp  <= 1'b0;
      rp  <= 1'b0;
      cnt <= 2'h0;
    end else begin
      if (push) wp <= ~wp;
      if (pop) rp <= ~rp;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Storage, written only on a push
  always_ff @(posedge core_clk_i) begin
    if (push && !flush_i) mem[wp] <= in_data_i;
  end

endmodule
`default_nettype wire

// [verif/hpc_periph_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Connector-side peripheral: drives pins and request pulses
module hpc_periph_model (
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       req_go_i,  // Start one request pulse
  input  wire logic [7:0] pat_i,     // Level the peripheral drives
  input  wire logic       dev_oe_i,  // Device drives the pins
  input  wire logic [7:0] dev_out_i, // Device drive value
  output logic            req_o,     // Request line
  output logic      [7:0] pins_o     // Resolved pin level
);
  logic [1:0] cnt; // Cycles of request left high

  // Whoever is enabled sets the pin level
  assign pins_o = dev_oe_i ? dev_out_i : pat_i;
  assign req_o  = (cnt != 2'h0);

  // Request high two cycles, then low so the next rise shows
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 2'h0;
    end else if (req_go_i) begin
      cnt <= 2'h2;
    end else if (cnt != 2'h0) begin
      cnt <= cnt - 2'h1;
    end
  end
endmodule
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench of the handshake port block
module tb;
  import hpc_pkg::*;

  logic        core_clk_i; // Core clock
  logic        rstn_i;     // Reset, active low
  hpc_bus_t    bus_q;      // Register bus request
  logic [15:0] rdata;      // Read data
  logic        wr_ready;   // Port B buffer has room
  logic        group1_request_line;       // Group one request
  logic        req_go;     // Starts a request pulse
  logic [7:0]  pat_b;      // Peripheral level on port B
  logic [7:0]  pat_d;      // Peripheral level on port D
  logic [7:0]  pins_b;     // Port B wire level
  logic [7:0]  pins_d;     // Port D wire level
  logic [7:0]  out_b;      // Port B drive value
  logic [7:0]  out_d;      // Port D drive value
  logic        oe_b;       // Port B drive enable
  logic        oe_d;       // Port D drive enable
  logic        group2_acknowledge_line;       // Group two acknowledge
  logic        extra_output_two;       // Extra output two
  logic        hs_b;       // Port B handshake active
  logic        hs_d;       // Port D handshake active
  logic [15:0] v;          // Scratch word
  logic [7:0]  w [4];      // Words sent in double mode
  int          err_count;
  int          n_checks;
  int          seed;

  hpc_port_cfg dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .bus_i(bus_q),
    .rdata_o(rdata), .portb_wr_ready_o(wr_ready), .group1_request_line_i(group1_request_line),
    .portb_in_i(pins_b), .portb_out_o(out_b), .portb_oe_o(oe_b), .portd_in_i(pins_d),
    .portd_out_o(out_d), .portd_oe_o(oe_d), .group2_acknowledge_line_o(group2_acknowledge_line),
    .extra_output_two_o(extra_output_two), .portb_handshake_active_o(hs_b), .portd_handshake_active_o(hs_d));
  hpc_periph_model model_b (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_go_i(req_go),
    .pat_i(pat_b), .dev_oe_i(oe_b), .dev_out_i(out_b), .req_o(group1_request_line), .pins_o(pins_b));
  hpc_periph_model model_d (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_go_i(1'b0),
    .pat_i(pat_d), .dev_oe_i(oe_d), .dev_out_i(out_d), .req_o(), .pins_o(pins_d));

  // ========================================================
  // Clock and watchdog
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  initial begin
    #100000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end

  // ========================================================
  // Helpers
  // Acknowledge level: invert flips the asserted level
  function automatic logic exp_ack(input logic [2:0] c);
    return c[2] ? !c[1] : c[1];
  endfunction

  // Word compare, bits are zero-extended by the caller
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write, returns one edge after it is taken
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus_q.wr <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask

  // One-cycle read, data sampled in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk_i);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge core_clk_i);
    bus_q.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Request pulse from the peripheral, then let it settle
  task automatic send_req();
    @(posedge core_clk_i);
    req_go <= 1'b1;
    @(posedge core_clk_i);
    req_go <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    #1;
  endtask

  // Print counts and verdict, then stop
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ========================================================
  // Main sequence
  initial begin
    seed = 61306;
    err_count = 0;
    n_checks = 0;
    bus_q = '0;
    req_go = 1'b0;
    pat_b = 8'h00;
    pat_d = 8'h00;
    rstn_i = 1'b0;
    repeat (2) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    @(posedge core_clk_i);
    #1;
    // Values after reset
    chk({oe_b, oe_d, group2_acknowledge_line, extra_output_two, wr_ready, hs_b, hs_d, 9'h000}, 16'h0800);
    chk({out_b, out_d}, 16'h0000);
    rd_reg(OFS_XFER, v);
    chk(v, 16'h0000);
    rd_reg(OFS_STATUS, v);
    chk(v, 16'h0002);
    // Every setting of acknowledge and extra output bits
    for (int i = 0; i < 8; i++) begin
      wr_reg(OFS_G2CFG, {13'h0000, i[2:0]});
      chk({14'h0000, group2_acknowledge_line, extra_output_two}, {14'h0000, exp_ack(i[2:0]), i[0]});
    end
    // Random transfer configurations set the directions
    for (int i = 0; i < 8; i++) begin
      v = 16'($random(seed));
      wr_reg(OFS_XFER, v);
      chk({14'h0000, oe_d, oe_b}, {14'h0000, v[14], v[13]});
    end
    rd_reg(8'h3C, v);
    chk(v, 16'h0000);
    // Single buffer: word reaches the pins at once
    wr_reg(OFS_XFER, 16'h0000);
    wr_reg(OFS_XFER, 16'h2000);
    w[0] = 8'($random(seed));
    wr_reg(OFS_PORTB, {8'h00, w[0]});
    chk({8'h00, out_b}, {8'h00, w[0]});
    // Double buffer: fill until refused, then drain by requests
    wr_reg(OFS_XFER, 16'h0000);
    wr_reg(OFS_XFER, 16'hA000);
    for (int k = 0; k < 4; k++) begin
      w[k] = 8'($random(seed));
      wr_reg(OFS_PORTB, {8'h00, w[k]});
      if (k == 2) begin
        chk({15'h0000, wr_ready}, 16'h0000);
      end
    end
    chk({8'h00, out_b}, {8'h00, PORT_RST});
    for (int k = 0; k < 4; k++) begin
      send_req();
      chk({8'h00, out_b}, {8'h00, w[(k < 3) ? k : 2]});
    end
    chk({15'h0000, wr_ready}, 16'h0001);
    // Group one local reset disarms until the enable rises
    wr_reg(OFS_G1CFG, 16'h0100);
    wr_reg(OFS_G1CFG, 16'h0000);
    repeat (2) @(posedge core_clk_i);
    w[3] = ~w[2];
    wr_reg(OFS_PORTB, {8'h00, w[3]});
    send_req();
    chk({8'h00, out_b}, {8'h00, w[2]});
    chk({15'h0000, hs_b}, 16'h0000);
    wr_reg(OFS_G1CFG, 16'h0001);
    chk({15'h0000, hs_b}, 16'h0001);
    send_req();
    chk({8'h00, out_b}, {8'h00, w[3]});
    // Double-buffered input latches, plain input is live
    wr_reg(OFS_XFER, 16'h8000);
    pat_b = 8'($random(seed));
    // Read right after the latching edge while the pins move on
    @(posedge core_clk_i);
    req_go <= 1'b1;
    @(posedge core_clk_i);
    req_go <= 1'b0;
    @(posedge core_clk_i);
    pat_b <= ~pat_b;
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: OFS_PORTB, wdata: 16'h0000};
    @(posedge core_clk_i);
    bus_q.rd <= 1'b0;
    #1;
    chk(rdata, {8'h00, ~pat_b});
    wr_reg(OFS_XFER, 16'h0000);
    rd_reg(OFS_PORTB, v);
    chk(v, {8'h00, pat_b});
    // Port D handshake, group two local reset and re-arm
    wr_reg(OFS_G2CFG, 16'h0402);
    wr_reg(OFS_XFER, 16'h4000);
    chk({14'h0000, group2_acknowledge_line, hs_d}, 16'h0003);
    wr_reg(OFS_PORTD, 16'h005A);
    chk({8'h00, out_d}, 16'h005A);
    wr_reg(OFS_G2CFG, 16'h0502);
    wr_reg(OFS_G2CFG, 16'h0402);
    repeat (2) @(posedge core_clk_i);
    #1;
    chk({14'h0000, group2_acknowledge_line, hs_d}, 16'h0000);
    wr_reg(OFS_G2CFG, 16'h0402);
    chk({14'h0000, group2_acknowledge_line, hs_d}, 16'h0003);
    wr_reg(OFS_G2CFG, 16'h0002);
    chk({15'h0000, hs_d}, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire
